// file: hw/iq_capture.sv
// Purpose: Sampling clock source, mode driver and word capture for the converter
// Assumes: Mode request is a static level from same-clock logic
// Notes:   Words inside the recovery window are dropped, not flagged
`timescale 1ns/1ns
`default_nettype none
module iq_capture
    import iq_conv_pkg::*;
#(
    parameter int unsigned DIV = SAMPLE_DIV
) (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    iq_conv_if.capture                 pins,
    input  wire logic [1:0]            mode_request,
    output logic      [WORD_WIDTH-1:0] i_capture,
    output logic                       i_capture_valid,
    output logic      [WORD_WIDTH-1:0] q_capture,
    output logic                       q_capture_valid
);

    localparam int unsigned DIV_USED = (DIV < 2) ? 2 : ((DIV > MAX_SAMPLE_DIV) ? MAX_SAMPLE_DIV : DIV);
    localparam int unsigned DIV_W    = $clog2(DIV_USED);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_USED - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(DIV_USED * DUTY_PERCENT / 100);
    localparam logic [4:0]       REC_LAST = 5'(RECOVERY_CYCLES);

    logic [DIV_W-1:0]      div_q, div_d;
    logic [1:0]            mode_q, mode_d;
    logic [4:0]            rec_q [2];
    logic [4:0]            rec_d [2];
    logic                  active [2];
    logic [WORD_WIDTH-1:0] i_cap_q, i_cap_d, q_cap_q, q_cap_d;
    logic                  i_val_q, i_val_d, q_val_q, q_val_d;
    logic                  tick;

    // Divider capped so the sampling rate stays at or above the floor; halves are equal only for an even DIV
    always_comb begin
        div_d = (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
        tick  = (div_q == '0);
        mode_d = mode_request;
        active[0] = (mode_q != MODE_ALL_STANDBY);
        active[1] = (mode_q == MODE_IN_PHASE) || (mode_q == MODE_Q_DELAYED);
    end

    // Recovery count restarts from standby and from reset (power-up)
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            rec_d[c] = rec_q[c];
            if (!active[c]) begin
                rec_d[c] = '0;
            end else if (tick && rec_q[c] != REC_LAST) begin
                rec_d[c] = rec_q[c] + 5'h01;
            end
        end
    end

    // Words sit stable a full period before this tick, except delayed Q, which moves on half_tick, half a period before
    always_comb begin
        i_cap_d = i_cap_q;
        q_cap_d = q_cap_q;
        i_val_d = 1'b0;
        q_val_d = 1'b0;
        if (tick && active[0] && rec_q[0] == REC_LAST) begin
            i_cap_d = pins.i_word;
            i_val_d = 1'b1;
        end
        if (tick && active[1] && rec_q[1] == REC_LAST) begin
            q_cap_d = pins.q_word;
            q_val_d = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_q    <= '0;
            mode_q   <= MODE_ALL_STANDBY;
            rec_q[0] <= '0;
            rec_q[1] <= '0;
            i_cap_q  <= WORD_RESET;
            q_cap_q  <= WORD_RESET;
            i_val_q  <= 1'b0;
            q_val_q  <= 1'b0;
        end else begin
            div_q   <= div_d;
            mode_q  <= mode_d;
            rec_q   <= rec_d;
            i_cap_q <= i_cap_d;
            q_cap_q <= q_cap_d;
            i_val_q <= i_val_d;
            q_val_q <= q_val_d;
        end
    end

    assign pins.sample_tick        = rst_n && tick;
    assign pins.half_tick          = rst_n && (div_q == DIV_HALF);
    assign pins.mode_select_first  = mode_q[1];
    assign pins.mode_select_second = mode_q[0];
    assign i_capture       = i_cap_q;
    assign i_capture_valid = i_val_q;
    assign q_capture       = q_cap_q;
    assign q_capture_valid = q_val_q;

endmodule : iq_capture
`default_nettype wire

// file: hw/iq_conv_if.sv
// Purpose: Pins between the converter and the logic that clocks and captures it
// Assumes: Ticks are one-cycle pulses of the shared system clock
// Notes:   Mode pins are static levels, asynchronous to the ticks
`timescale 1ns/1ns
`default_nettype none
interface iq_conv_if;
    import iq_conv_pkg::*;

    logic                  sample_tick;
    logic                  half_tick;
    logic                  mode_select_first;
    logic                  mode_select_second;
    logic [WORD_WIDTH-1:0] i_word;
    logic [WORD_WIDTH-1:0] q_word;

    modport converter (
        input  sample_tick,
        input  half_tick,
        input  mode_select_first,
        input  mode_select_second,
        output i_word,
        output q_word
    );

    modport capture (
        output sample_tick,
        output half_tick,
        output mode_select_first,
        output mode_select_second,
        input  i_word,
        input  q_word
    );
endinterface : iq_conv_if
`default_nettype wire

// file: hw/iq_conv_pkg.sv
// Purpose: Shared constants for the dual-channel converter model and its capture end
// Assumes: One 250 MHz system clock; the sampling clock is an enable pulse pair
// Notes:   Mode codes are {mode_select_first, mode_select_second}
package iq_conv_pkg;

    localparam int unsigned WORD_WIDTH      = 10;
    localparam int unsigned CLOCK_MHZ       = 250;
    localparam int unsigned MIN_RATE_MSPS   = 1;
    localparam int unsigned SAMPLE_DIV      = 8;
    localparam int unsigned MAX_SAMPLE_DIV  = CLOCK_MHZ / MIN_RATE_MSPS;
    localparam int unsigned LATENCY_CYCLES  = 6;
    localparam int unsigned RECOVERY_CYCLES = 20;
    localparam int unsigned DUTY_PERCENT    = 50;

    localparam logic [1:0] MODE_ALL_STANDBY = 2'b00;
    localparam logic [1:0] MODE_Q_STANDBY   = 2'b01;
    localparam logic [1:0] MODE_IN_PHASE    = 2'b10;
    localparam logic [1:0] MODE_Q_DELAYED   = 2'b11;

    localparam logic [WORD_WIDTH-1:0] WORD_RESET = 10'h200;

endpackage : iq_conv_pkg

// file: hw/iq_converter.sv
// Purpose: Digital side of the dual I/Q converter: mode control, latency, output words
// Assumes: sample_tick marks the sampling clock rise, half_tick its fall
// Notes:   Analog conversion is stood in for by signed input codes on the user side
// Behaviour
// - Mode pins sampled freely, no tick alignment
// - Mode 00 stands both channels by
// - Mode 01 runs I, Q standby
// - Mode 10 runs both in phase
// - Mode 11 puts Q 180 degrees out
// - Delayed mode shifts Q half a cycle
// - Standby freezes outputs, still driven
// - Words invalid for 20 cycles after standby
// - Power-up needs 20 fast cycles first
// - Sampling clock must exceed 1 MSPS
// - Clock duty 50 percent, low jitter
// - Delayed mode aligns inverted-clock systems
// - Word appears six cycles after sampling
// - Output words coded in offset binary
`timescale 1ns/1ns
`default_nettype none
module iq_converter
    import iq_conv_pkg::*;
#(
    parameter int unsigned LATENCY = LATENCY_CYCLES
) (
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    iq_conv_if.converter                      pins,
    input  wire logic signed [WORD_WIDTH-1:0] i_analog,
    input  wire logic signed [WORD_WIDTH-1:0] q_analog
);

    logic [1:0]            mode_sync1_q, mode_sync1_d;
    logic [1:0]            mode_sync2_q, mode_sync2_d;
    logic [WORD_WIDTH-1:0] i_pipe_q [LATENCY];
    logic [WORD_WIDTH-1:0] i_pipe_d [LATENCY];
    logic [WORD_WIDTH-1:0] q_pipe_q [LATENCY];
    logic [WORD_WIDTH-1:0] q_pipe_d [LATENCY];
    logic [WORD_WIDTH-1:0] i_word_q, i_word_d;
    logic [WORD_WIDTH-1:0] q_word_q, q_word_d;
    logic [WORD_WIDTH-1:0] q_hold_q, q_hold_d;
    logic                  i_active;
    logic                  q_active;
    logic                  q_delayed;

    // Mode pins cross in through two flops; no alignment to either tick
    always_comb begin
        mode_sync1_d = {pins.mode_select_first, pins.mode_select_second};
        mode_sync2_d = mode_sync1_q;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_sync1_q <= MODE_ALL_STANDBY;
            mode_sync2_q <= MODE_ALL_STANDBY;
        end else begin
            mode_sync1_q <= mode_sync1_d;
            mode_sync2_q <= mode_sync2_d;
        end
    end

    always_comb begin
        i_active  = (mode_sync2_q != MODE_ALL_STANDBY);
        q_active  = (mode_sync2_q == MODE_IN_PHASE) || (mode_sync2_q == MODE_Q_DELAYED);
        q_delayed = (mode_sync2_q == MODE_Q_DELAYED);
    end

    // Pipeline advances only on sampling ticks of an active channel
    always_comb begin
        for (int k = 0; k < LATENCY; k++) begin
            i_pipe_d[k] = i_pipe_q[k];
            q_pipe_d[k] = q_pipe_q[k];
        end
        if (pins.sample_tick && i_active) begin
            i_pipe_d[0] = {~i_analog[WORD_WIDTH-1], i_analog[WORD_WIDTH-2:0]};
            for (int k = 1; k < LATENCY; k++) begin
                i_pipe_d[k] = i_pipe_q[k-1];
            end
        end
        if (pins.sample_tick && q_active) begin
            q_pipe_d[0] = {~q_analog[WORD_WIDTH-1], q_analog[WORD_WIDTH-2:0]};
            for (int k = 1; k < LATENCY; k++) begin
                q_pipe_d[k] = q_pipe_q[k-1];
            end
        end
    end

    // Output words: frozen, never floated, while the channel stands by
    always_comb begin
        i_word_d = i_word_q;
        q_word_d = q_word_q;
        q_hold_d = q_hold_q;
        if (pins.sample_tick && i_active) begin
            i_word_d = i_pipe_q[LATENCY-1];
        end
        // The pipe has shifted by the falling half, so the word due this period is held aside
        if (pins.sample_tick && q_active) begin
            q_hold_d = q_pipe_q[LATENCY-1];
        end
        if (q_active && (q_delayed ? pins.half_tick : pins.sample_tick)) begin
            q_word_d = q_delayed ? q_hold_q : q_pipe_q[LATENCY-1];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < LATENCY; k++) begin
                i_pipe_q[k] <= WORD_RESET;
                q_pipe_q[k] <= WORD_RESET;
            end
            i_word_q <= WORD_RESET;
            q_word_q <= WORD_RESET;
            q_hold_q <= WORD_RESET;
        end else begin
            i_pipe_q <= i_pipe_d;
            q_pipe_q <= q_pipe_d;
            i_word_q <= i_word_d;
            q_word_q <= q_word_d;
            q_hold_q <= q_hold_d;
        end
    end

    assign pins.i_word = i_word_q;
    assign pins.q_word = q_word_q;

endmodule : iq_converter
`default_nettype wire

// file: test/dual_adc_mode_and_output_control_tb.sv
// Purpose: Self-checking bench for the converter and its capture end
// Assumes: DIV of 4 keeps recovery waits short
// Notes:   Inputs change on the falling edge only
`timescale 1ns/1ns
`default_nettype none
module dual_adc_mode_and_output_control_tb;
    import iq_conv_pkg::*;
    localparam int unsigned DIV = 4;
    logic                         clock;
    logic                         rst_n;
    logic [1:0]                   mode_request;
    logic signed [WORD_WIDTH-1:0] i_analog;
    logic signed [WORD_WIDTH-1:0] q_analog;
    logic [WORD_WIDTH-1:0]        i_capture;
    logic [WORD_WIDTH-1:0]        q_capture;
    logic                         i_capture_valid;
    logic                         q_capture_valid;
    int                           n_fail = 0;
    int                           checks_done = 0;
    int                           cycles = 0;
    iq_conv_if link();
    iq_converter iq_converter_inst (.clock(clock), .rst_n(rst_n), .pins(link),
        .i_analog(i_analog), .q_analog(q_analog));
    iq_capture #(.DIV(DIV)) iq_capture_inst (.clock(clock), .rst_n(rst_n), .pins(link),
        .mode_request(mode_request), .i_capture(i_capture), .i_capture_valid(i_capture_valid),
        .q_capture(q_capture), .q_capture_valid(q_capture_valid));
    iq_link_asserts #(.DIV(DIV)) iq_link_asserts_inst (.clock(clock), .rst_n(rst_n),
        .sample_tick(link.sample_tick), .half_tick(link.half_tick),
        .mode_select_first(link.mode_select_first),
        .mode_select_second(link.mode_select_second), .i_word(link.i_word), .q_word(link.q_word));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask : check
    // Skip the first cycles so words launched before the mode sync are not counted
    task automatic run_mode(input logic [1:0] m, input logic [9:0] iv, input logic [9:0] qv,
                            input logic ie, input logic qe);
        logic si;
        logic sq;
        si = 1'b0;
        sq = 1'b0;
        mode_request = m;
        i_analog = iv;
        q_analog = qv;
        repeat (8) @(negedge clock);
        repeat (200) begin
            @(negedge clock);
            si |= i_capture_valid;
            sq |= q_capture_valid;
        end
        check("i valid", {9'h000, ie}, {9'h000, si});
        check("q valid", {9'h000, qe}, {9'h000, sq});
        if (ie) check("i data", iv ^ 10'h200, i_capture);
        if (qe) check("q data", qv ^ 10'h200, q_capture);
        $display("test run_mode %b done", m);
    endtask : run_mode
    task automatic phase_gap(input logic [9:0] gap);
        logic [9:0] iw;
        logic [9:0] qw;
        int         n;
        iw = link.i_word;
        qw = link.q_word;
        i_analog = i_analog + 10'sh003;
        q_analog = q_analog + 10'sh003;
        n = 0;
        while (link.i_word === iw && n < 100) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        while (link.q_word === qw && n < 10) begin
            @(negedge clock);
            n++;
        end
        check("q gap", gap, 10'(n));
        $display("test phase_gap done");
    endtask : phase_gap
    task automatic freeze();
        int n;
        n = 0;
        mode_request = 2'b00;
        repeat (8) @(negedge clock);
        i_analog = 10'sh055;
        q_analog = 10'sh066;
        repeat (100) begin
            @(negedge clock);
            n += i_capture_valid + q_capture_valid;
        end
        check("i frozen", 10'h205, link.i_word);
        check("q frozen", 10'h204, link.q_word);
        check("standby valids", 10'h000, 10'(n));
        $display("test freeze done");
    endtask : freeze
    task automatic recover();
        int n;
        n = 0;
        mode_request = 2'b10;
        while (!i_capture_valid && n < 200) begin
            @(negedge clock);
            n++;
        end
        check("recovery window", 10'h001, {9'h000, n >= 20 * DIV && n <= 20 * DIV + 20});
        check("recovered data", 10'h255, i_capture);
        $display("test recover done");
    endtask : recover
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        rst_n = 1'b0;
        mode_request = 2'b00;
        i_analog = '0;
        q_analog = '0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        run_mode(2'b10, 10'h1ff, 10'h200, 1'b1, 1'b1);
        phase_gap(10'h000);
        run_mode(2'b11, 10'h000, 10'h001, 1'b1, 1'b1);
        phase_gap(10'(DIV / 2));
        run_mode(2'b01, 10'h005, 10'h007, 1'b1, 1'b0);
        freeze();
        recover();
        conclude();
    end
endmodule : dual_adc_mode_and_output_control_tb
`default_nettype wire

// file: test/iq_link_asserts.sv
// Purpose: Concurrent checks on the converter link pins
// Assumes: One clock; ticks and mode pins come from the capture end
// Notes:   Mode windows span four cycles to cover the two-flop mode sync
`timescale 1ns/1ns
`default_nettype none
module iq_link_asserts
    import iq_conv_pkg::*;
#(
    parameter int unsigned DIV = SAMPLE_DIV
) (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  sample_tick,
    input wire logic                  half_tick,
    input wire logic                  mode_select_first,
    input wire logic                  mode_select_second,
    input wire logic [WORD_WIDTH-1:0] i_word,
    input wire logic [WORD_WIDTH-1:0] q_word
);
    logic [7:0] gap_q;
    logic [7:0] gap_d;
    logic [1:0] mode;
    assign mode = {mode_select_first, mode_select_second};
    always_comb begin
        gap_d = sample_tick ? 8'h00 : gap_q + 8'h01;
    end
    // Preset so the first tick after reset sees a full period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) gap_q <= 8'(DIV - 1);
        else gap_q <= gap_d;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    tick_period_a: assert property (sample_tick |-> gap_q == 8'(DIV - 1))
        else $error("sample tick off period");
    half_point_a: assert property (half_tick |-> gap_q == 8'(DIV / 2 - 1))
        else $error("half tick off midpoint");
    ticks_apart_a: assert property (!(sample_tick && half_tick))
        else $error("ticks coincide");
    i_frozen_a: assert property ((mode == 2'b00) [*4] |=> $stable(i_word))
        else $error("i word moved in standby");
    q_frozen_a: assert property ((!mode_select_first) [*4] |=> $stable(q_word))
        else $error("q word moved in standby");
    i_update_a: assert property ($changed(i_word) |-> $past(sample_tick))
        else $error("i word moved off tick");
    q_in_phase_a: assert property ((mode == 2'b10) [*4] ##1 $changed(q_word)
        |-> $past(sample_tick)) else $error("q word not in phase");
    q_delayed_a: assert property ((mode == 2'b11) [*4] ##1 $changed(q_word)
        |-> $past(half_tick)) else $error("q word not on half tick");
endmodule : iq_link_asserts
`default_nettype wire
